// file: asrc_pkg.sv
// package for the async sram host controller: timing counts and state codes
// assumes a single 20 mhz core clock driving every sequencer
package asrc_pkg;
	// core clock period in ns
	localparam int CLK_PERIOD_NS = 50;
	// power-up wait before first access, in us
	localparam int POWER_WAIT_US = 100;
	localparam int POWER_WAIT_CYC = (POWER_WAIT_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// device timing figures in ns
	localparam int ADDR_SETUP_NS = 7;
	localparam int DATA_SETUP_NS = 5;
	localparam int STORE_FLOAT_NS = 5;
	localparam int ACCESS_NS = 10;
	// minimum write-strobe low time: float delay plus data setup, at least addr setup
	localparam int WR_LOW_NS = (STORE_FLOAT_NS + DATA_SETUP_NS > ADDR_SETUP_NS)
		? STORE_FLOAT_NS + DATA_SETUP_NS : ADDR_SETUP_NS;
	localparam int WR_LOW_CYC = (WR_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// read strobe low time covering address access delay
	localparam int RD_LOW_CYC = (ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS + 1;
	localparam int CNT_W = 8;
	localparam int ADDR_W = 21;
	localparam int DATA_W = 8;
	// sequencer states
	typedef enum logic [5:0] {
		ST_POWER = 6'b00_0001,
		ST_IDLE  = 6'b00_0010,
		ST_WSET  = 6'b00_0100,
		ST_WLOW  = 6'b00_1000,
		ST_RLOW  = 6'b01_0000,
		ST_END   = 6'b10_0000
	} asrc_state_t;
endpackage

// file: asrc_delay.sv
// power-up wait counter: raises done after a programmable number of cycles
// assumes synchronous active-high reset on core_clk
module asrc_delay #(
	parameter int CYCLES = 2000
) (
	// clock and reset
	input  wire logic core_clk,
	input  wire logic reset,
	// status
	output logic      done
);
	localparam int CW = $clog2(CYCLES + 1);
	logic [CW-1:0] count;
	logic [CW-1:0] next_count;
	logic          next_done;

	// count up until the wait expires, then hold
	always_comb
	begin
		next_count = count;
		next_done = done;
		if (count == CW'(CYCLES))
			next_done = 1'b1;
		else
			next_count = count + CW'(1);
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			count <= '0;
			done <= 1'b0;
		end
		else
		begin
			count <= next_count;
			done <= next_done;
		end
	end
endmodule // asrc_delay

// file: asrc_host.sv
// host-side sequencer driving a 2m x 8 asynchronous static memory
// assumes pins sampled synchronously to core_clk and the memory obeys its own timing
//
// Behaviour
// - select and store strobes both low writes data pins to the addressed location.
// - select and output-drive low with store high makes device drive read data.
// - write starts on both strobes low and ends on either rising.
// - write data stable five ns before write end, held zero ns after.
// - address stable seven ns before the write-ending strobe edge.
// - address unchanged until at least zero ns after write end.
// - address valid no later than the start of the strobe overlap.
// - with output-drive low, write pulse spans float delay plus data setup.
// - host waits at least one hundred us after power-up before accessing.
// - host never drives data pins while the device may still drive them.
module asrc_host
	import asrc_pkg::*;
#(
	parameter int POWER_CYC = POWER_WAIT_CYC
) (
	// clock and reset
	input  wire logic              core_clk,
	input  wire logic              reset,
	// user request
	input  wire logic              reqValid,
	input  wire logic              reqWrite,
	input  wire logic [ADDR_W-1:0] reqAddr,
	input  wire logic [DATA_W-1:0] reqData,
	output logic                   reqReady,
	output logic                   rdValid,
	output logic [DATA_W-1:0]      rdData,
	// memory pins
	output logic [ADDR_W-1:0]      memAddr,
	output logic                   memSelect_n,
	output logic                   memStore_n,
	output logic                   memOutDrive_n,
	output logic [DATA_W-1:0]      memDataOut,
	output logic                   memDataOe,
	input  wire logic [DATA_W-1:0] memDataIn
);
	asrc_state_t       state;
	asrc_state_t       next_state;
	logic [CNT_W-1:0]  count;
	logic [CNT_W-1:0]  next_count;
	logic [ADDR_W-1:0] next_memAddr;
	logic              next_memSelect_n;
	logic              next_memStore_n;
	logic              next_memOutDrive_n;
	logic [DATA_W-1:0] next_memDataOut;
	logic              next_memDataOe;
	logic              next_reqReady;
	logic              next_rdValid;
	logic [DATA_W-1:0] next_rdData;
	logic              powerDone;

	// power-up wait before first access
	asrc_delay #(
		.CYCLES (POWER_CYC)
	) u_power (
		.core_clk (core_clk),
		.reset    (reset),
		.done     (powerDone)
	);

	// sequencer: every access is a fixed cycle count
	always_comb
	begin
		next_state = state;
		next_count = count;
		next_memAddr = memAddr;
		next_memSelect_n = memSelect_n;
		next_memStore_n = memStore_n;
		next_memOutDrive_n = memOutDrive_n;
		next_memDataOut = memDataOut;
		next_memDataOe = memDataOe;
		next_reqReady = 1'b0;
		next_rdValid = 1'b0;
		next_rdData = rdData;
		case (state)
			ST_POWER:
			begin
				if (powerDone) // no access before the wait
				begin
					next_state = ST_IDLE;
					next_reqReady = 1'b1;
				end
			end
			ST_IDLE:
			begin
				next_reqReady = 1'b1;
				if (reqValid)
				begin
					next_reqReady = 1'b0;
					next_memAddr = reqAddr; // address set before write strobes fall, together with select on reads
					next_count = '0;
					if (reqWrite)
					begin
						// output-drive kept high so the device floats
						next_memOutDrive_n = 1'b1;
						next_memDataOut = reqData;
						next_state = ST_WSET;
					end
					else
					begin
						next_memSelect_n = 1'b0; // read condition
						next_memOutDrive_n = 1'b0;
						next_state = ST_RLOW;
					end
				end
			end
			ST_WSET:
			begin
				// both strobes fall together, data driven from here
				next_memSelect_n = 1'b0;
				next_memStore_n = 1'b0;
				next_memDataOe = 1'b1;
				next_state = ST_WLOW;
			end
			ST_WLOW:
			begin
				// hold pulse long enough for setup and float delay
				if (count >= CNT_W'(WR_LOW_CYC - 1))
				begin
					next_memSelect_n = 1'b1;
					next_memStore_n = 1'b1; // rising edge ends the write
					next_state = ST_END;
				end
				else
					next_count = count + CNT_W'(1);
			end
			ST_RLOW:
			begin
				// wait out access delay, then latch data
				if (count >= CNT_W'(RD_LOW_CYC - 1))
				begin
					next_rdData = memDataIn;
					next_rdValid = 1'b1;
					next_memSelect_n = 1'b1; // deselect lets device stand
					next_memOutDrive_n = 1'b1;
					next_state = ST_END;
				end
				else
					next_count = count + CNT_W'(1);
			end
			ST_END:
			begin
				// address and data held one cycle past strobe rise
				next_memDataOe = 1'b0;
				next_reqReady = 1'b1;
				next_state = ST_IDLE;
			end
			default:
				next_state = ST_POWER;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			state <= ST_POWER;
			count <= '0;
			memAddr <= '0;
			memSelect_n <= 1'b1;
			memStore_n <= 1'b1;
			memOutDrive_n <= 1'b1;
			memDataOut <= '0;
			memDataOe <= 1'b0;
			reqReady <= 1'b0;
			rdValid <= 1'b0;
			rdData <= '0;
		end
		else
		begin
			state <= next_state;
			count <= next_count;
			memAddr <= next_memAddr;
			memSelect_n <= next_memSelect_n;
			memStore_n <= next_memStore_n;
			memOutDrive_n <= next_memOutDrive_n;
			memDataOut <= next_memDataOut;
			memDataOe <= next_memDataOe;
			reqReady <= next_reqReady;
			rdValid <= next_rdValid;
			rdData <= next_rdData;
		end
	end

	// named steps of a write
	sequence s_wr_start;
		!memSelect_n && !memStore_n;
	endsequence
	sequence s_wr_end;
		memSelect_n && memStore_n;
	endsequence

	AST_NO_CONTENTION: assert property (@(posedge core_clk) disable iff (reset)
		memDataOe |-> memOutDrive_n)
		else $error("host drives data while device output enabled");
	AST_WR_DATA_ON: assert property (@(posedge core_clk) disable iff (reset)
		s_wr_start |-> memDataOe)
		else $error("write strobes low without data driven");
	// pulse must last its full count and end with both strobes rising together
	AST_WR_PULSE: assert property (@(posedge core_clk) disable iff (reset)
		$fell(memStore_n) |-> !memStore_n && !memSelect_n ##1 s_wr_end)
		else $error("write pulse wrong length or strobes not ended together");
	AST_ADDR_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		s_wr_start |=> $stable(memAddr))
		else $error("address moved during write");
	AST_DATA_HOLD: assert property (@(posedge core_clk) disable iff (reset)
		(s_wr_start ##1 s_wr_end) |-> memDataOe && $stable(memDataOut))
		else $error("data not held past write end");
	// reads may move address and select together, writes may not
	AST_ADDR_SETUP: assert property (@(posedge core_clk) disable iff (reset)
		$fell(memStore_n) |-> $stable(memAddr))
		else $error("address changed at write start");
	AST_READ_DONE: assert property (@(posedge core_clk) disable iff (reset)
		($fell(memSelect_n) && memStore_n) |-> ##[1:4] rdValid)
		else $error("read not completed in time");
	AST_POWER_WAIT: assert property (@(posedge core_clk) disable iff (reset)
		!powerDone |-> memSelect_n)
		else $error("access before power-up wait");
endmodule // asrc_host

// file: asrc_sram_model.sv
// behavioural model of the asynchronous static memory at the host's pins
// assumes the host drives pins from registers clocked by core_clk
module asrc_sram_model
	import asrc_pkg::*;
(
	// strobes and address
	input  wire logic [ADDR_W-1:0] memAddr,
	input  wire logic              memSelect_n,
	input  wire logic              memStore_n,
	input  wire logic              memOutDrive_n,
	// data lines
	input  wire logic [DATA_W-1:0] memDataOut,
	input  wire logic              memDataOe,
	output logic [DATA_W-1:0]      memDataIn,
	output logic                   clash
);
	timeunit 1ns;
	timeprecision 1ps;
	// old data lingers this long after the address moves
	localparam int HOLD_NS = 3;
	// two-state storage, so unwritten locations read as zero
	bit   [DATA_W-1:0] store [0:(1 << ADDR_W) - 1];
	logic [DATA_W-1:0] rdVal = 8'h00;
	logic [DATA_W-1:0] rdHold = 8'h00;
	logic [DATA_W-1:0] last = 8'h00;
	logic              drv = 1'b0;
	logic              wasWr = 1'b0;
	// unknown strobes before reset count as inactive
	wire rdCond = (memSelect_n === 1'b0) && (memOutDrive_n === 1'b0)
		&& (memStore_n === 1'b1);
	wire wrAct  = (memSelect_n === 1'b0) && (memStore_n === 1'b0);
	initial clash = 1'b0;
	// turn-off at once, turn-on after access delay, so drivers never overlap
	always @(rdCond)
	begin
		drv = 1'b0;
		if (rdCond)
		begin
			#ACCESS_NS;
			drv = rdCond;
		end
	end
	// capture on the edge that ends the overlap, then refresh the lookup
	always @(wrAct)
	begin
		if (wasWr && !wrAct)
		begin
			store[memAddr] = memDataOut;
			rdVal = store[memAddr];
		end
		wasWr = wrAct;
	end
	// look up again whenever the address moves
	always @(memAddr)
		rdVal = store[memAddr];
	// previous data stays on the pins briefly after an address change
	always @(rdVal)
		rdHold <= #HOLD_NS rdVal;
	// remember what was driven and flag any overlap with the host
	always @(drv, rdHold, memDataOe)
	begin
		if (drv)
			last = rdHold;
		if (drv && memDataOe)
			clash = 1'b1;
	end
	// a floating bus shows the inverse so a stale sample cannot match
	assign memDataIn = drv ? rdHold : (memDataOe ? memDataOut : ~last);
endmodule // asrc_sram_model

// file: tb_asrc_host.sv
// self-checking bench for the host sequencer against the memory model
// assumes a shortened power-up wait passed as POWER_CYC
module tb_asrc_host;
	timeunit 1ns;
	timeprecision 1ps;
	import asrc_pkg::*;
	localparam int PW = 10;
	logic core_clk = 0, reset = 1, reqValid = 0, reqWrite = 0;
	logic [ADDR_W-1:0] reqAddr = '0, memAddr;
	logic [DATA_W-1:0] reqData = '0, rdData, memDataOut, memDataIn;
	logic reqReady, rdValid, memSelect_n, memStore_n, memOutDrive_n, memDataOe;
	int err_count = 0, check_count = 0;
	asrc_host #(.POWER_CYC(PW)) dut (.core_clk(core_clk), .reset(reset),
		.reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr),
		.reqData(reqData), .reqReady(reqReady), .rdValid(rdValid),
		.rdData(rdData), .memAddr(memAddr), .memSelect_n(memSelect_n),
		.memStore_n(memStore_n), .memOutDrive_n(memOutDrive_n),
		.memDataOut(memDataOut), .memDataOe(memDataOe), .memDataIn(memDataIn));
	asrc_sram_model mem (.memAddr(memAddr), .memSelect_n(memSelect_n),
		.memStore_n(memStore_n), .memOutDrive_n(memOutDrive_n),
		.memDataOut(memDataOut), .memDataOe(memDataOe),
		.memDataIn(memDataIn), .clash());
	// 20 mhz clock
	initial forever #25 core_clk = ~core_clk;
	task chk_data(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp)
		begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task chk_bit(input string what, input logic exp, input logic got);
		chk_data(what, {7'h00, exp}, {7'h00, got});
	endtask
	// one request, held until the taking edge; reads judged at fixed latency
	task issue(input logic wr, input logic [20:0] a, input logic [7:0] d, input logic [7:0] e);
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 100)
		begin
			@(negedge core_clk);
			n++;
		end
		if (n >= 100)
			err_count++;
		reqValid = 1;
		reqWrite = wr;
		reqAddr = a;
		reqData = d;
		@(negedge core_clk);
		reqValid = 0;
		if (!wr)
		begin
			// result stands one cycle, RD_LOW_CYC edges after the taking edge
			repeat (RD_LOW_CYC - 1) @(negedge core_clk);
			chk_bit("rdValid early", 1'b0, rdValid);
			@(negedge core_clk);
			chk_bit("rdValid", 1'b1, rdValid);
			chk_data("rdData", e, rdData);
			@(negedge core_clk);
			chk_bit("rdValid pulse", 1'b0, rdValid);
		end
	endtask
	// ready only after the power-up wait
	task t_power;
		int n;
		n = 0;
		while (reqReady !== 1'b1 && n < 50)
		begin
			@(negedge core_clk);
			n++;
		end
		chk_data("power wait", 8'(PW + 2), 8'(n));
	endtask
	// boundary and alternating-bit addresses, write then read back to back
	task t_wr_rd;
		issue(1, 21'h00_0000, 8'hA5, 8'h00);
		issue(0, 21'h00_0000, 8'h00, 8'hA5);
		issue(1, 21'h1F_FFFF, 8'h3C, 8'h00);
		issue(0, 21'h1F_FFFF, 8'h00, 8'h3C);
		issue(1, 21'h0A_AAAA, 8'h5A, 8'h00);
		issue(0, 21'h0A_AAAA, 8'h00, 8'h5A);
		// the first location must survive the later writes
		issue(0, 21'h00_0000, 8'h00, 8'hA5);
	endtask
	// a request offered while busy is dropped, not queued
	task t_refuse;
		issue(1, 21'h00_1234, 8'h11, 8'h00);
		// let an edge pass so reqValid is not assigned twice in one step
		@(negedge core_clk);
		reqValid = 1;
		reqAddr = 21'h00_4321;
		reqData = 8'h22;
		@(negedge core_clk);
		reqValid = 0;
		issue(0, 21'h00_4321, 8'h00, 8'h00);
		issue(0, 21'h00_1234, 8'h00, 8'h11);
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// main sequence, inputs move on the falling edge
	initial
	begin
		repeat (3) @(negedge core_clk);
		reset = 0;
		t_power();
		t_wr_rd();
		t_refuse();
		chk_bit("bus clash", 1'b0, mem.clash);
		print_verdict();
	end
	// hang guard, far beyond the ten accesses above
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule // tb_asrc_host
